// [dv/scrc_checker.sv]
// port-level checks: register reads, location timing, clock rate, reset order
// assumes it is bound onto scrc_top
`default_nettype none
module scrc_checker
    import scrc_pkg::*;
(
    input wire logic        SYSTEM_CLOCK,
    input wire logic        RST,
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic        PWRITE,
    input wire logic [7:0]  PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [31:0] PRDATA,
    input wire logic        PREADY,
    input wire logic [5:0]  SHORT_IO_OFFSET,
    input wire logic [23:0] SHORT_IO_ADDRESS,
    input wire logic        CORE_CLK_EN,
    input wire logic        PERIPH_CLK_EN,
    input wire logic        CHIP_RESET,
    input wire logic        PERIPH_RESET,
    input wire logic        CORE_RESET
);
    default clocking cb @(posedge SYSTEM_CLOCK); endclocking
    default disable iff (RST);
    wire acc = PSEL && PENABLE && PREADY;
    property p_gate_fixed; acc && !PWRITE && PADDR == OFS_GATES |-> PRDATA[1]; endproperty
    property p_high_ones;
        acc && !PWRITE && PADDR == OFS_LOC_HIGH |-> PRDATA[15:2] == 14'h3fff;
    endproperty
    property p_offset; !$past(RST) |-> SHORT_IO_ADDRESS[5:0] == $past(SHORT_IO_OFFSET); endproperty
    property p_delay;
        acc && PWRITE && PADDR == OFS_LOC_LOW |=> $stable(SHORT_IO_ADDRESS[23:6])[*6]
            ##1 SHORT_IO_ADDRESS[21:6] == $past(PWDATA[15:0], 7);
    endproperty
    property p_per_half; PERIPH_CLK_EN |=> !PERIPH_CLK_EN; endproperty
    property p_core_half; CORE_CLK_EN |=> !CORE_CLK_EN; endproperty
    property p_order; $fell(CORE_RESET) |-> !PERIPH_RESET && !CHIP_RESET; endproperty
    property p_core_phase; $fell(PERIPH_RESET) |-> ##64 $fell(CORE_RESET); endproperty
    property p_rst_ones; $fell(RST) |-> SHORT_IO_ADDRESS[23:6] == 18'h3ffff; endproperty
    a_gate_fixed: assert property (p_gate_fixed) else $error("gate bit one low");
    a_high_ones: assert property (p_high_ones) else $error("high bits not ones");
    a_offset: assert property (p_offset) else $error("offset bits wrong");
    a_delay: assert property (p_delay) else $error("location delay wrong");
    a_per_half: assert property (p_per_half) else $error("periph rate high");
    a_core_half: assert property (p_core_half) else $error("core rate high");
    a_order: assert property (p_order) else $error("core released first");
    a_core_phase: assert property (p_core_phase) else $error("core phase length");
    a_rst_ones: assert property (p_rst_ones) else $error("location not ones");
    c_write: cover property (acc && PWRITE);
    c_boot: cover property ($fell(CORE_RESET));
    c_release: cover property ($fell(PERIPH_RESET));
endmodule
bind scrc_top scrc_checker u_chk (.SYSTEM_CLOCK(SYSTEM_CLOCK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .SHORT_IO_OFFSET(SHORT_IO_OFFSET), .SHORT_IO_ADDRESS(SHORT_IO_ADDRESS),
    .CORE_CLK_EN(CORE_CLK_EN), .PERIPH_CLK_EN(PERIPH_CLK_EN), .CHIP_RESET(CHIP_RESET),
    .PERIPH_RESET(PERIPH_RESET), .CORE_RESET(CORE_RESET));
`default_nettype wire

// [dv/scrc_partner.sv]
// far side: master clock tick and a peripheral interrupt source
// assumes the bench asks for interrupts by level
`default_nettype none
module scrc_partner (
    input  wire logic clk,
    input  wire logic irq_req,
    input  wire logic core_clk_en,
    output logic      master_tick,
    output logic      periph_irq
);
    timeunit 1ns;
    timeprecision 1ns;
    initial master_tick = 1'h1;
    initial periph_irq = 1'h0;
    // held until the core runs again
    always @(posedge clk) periph_irq <= irq_req && !(periph_irq && core_clk_en);
endmodule
`default_nettype wire

// [dv/tb_system_clock_reset_control.sv]
// bench: registers over APB, location timing, power modes, reset sources
// assumes scrc_partner supplies master tick and the peripheral interrupt
`default_nettype none
module tb_system_clock_reset_control
    import scrc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        SYSTEM_CLOCK = 1'h0, RST = 1'h1, xr = 1'h0, por = 1'h0, wd = 1'h0, er;
    logic        stp = 1'h0, wt = 1'h0, xi = 1'h0, can = 1'h0, exm = 1'h0, irq_req = 1'h0;
    logic        PSEL = 1'h0, PENABLE = 1'h0, PWRITE = 1'h0;
    logic [7:0]  PADDR = 8'h0;
    logic [5:0]  ofs = 6'h0;
    logic [31:0] PWDATA = 32'h0, rd;
    logic [15:0] g;
    wire         mt, irq, ce, pe, PREADY, PSLVERR, dok, chr, prr, crr;
    wire [31:0]  PRDATA;
    wire [15:0]  gen;
    wire [23:0]  sio;
    int          errors = 0, total_checks = 0, cyc = 0, n, c, p;
    always #10 SYSTEM_CLOCK = ~SYSTEM_CLOCK;
    scrc_top dut (.SYSTEM_CLOCK(SYSTEM_CLOCK), .RST(RST), .MASTER_CLK_EN(mt), .EXT_RESET(xr),
        .POR_DET_LOW(por), .WDOG_RESET(wd), .CORE_STOP_REQ(stp), .CORE_WAIT_REQ(wt),
        .PERIPH_IRQ(irq), .EXT_IRQ(xi), .CAN_ACTIVITY(can), .EXTERNAL_MEMORY_BIT(exm),
        .SHORT_IO_OFFSET(ofs), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
        .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
        .SHORT_IO_ADDRESS(sio), .DEBUG_ACCESS_OK(dok), .CORE_CLK_EN(ce), .PERIPH_CLK_EN(pe),
        .PERIPH_GATE_EN(gen), .CHIP_RESET(chr), .PERIPH_RESET(prr), .CORE_RESET(crr));
    scrc_partner u_far (.clk(SYSTEM_CLOCK), .irq_req(irq_req), .core_clk_en(ce), .master_tick(mt),
        .periph_irq(irq));
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k = 0;
        {PSEL, PENABLE, PWRITE, PADDR, PWDATA} <= {1'h1, 1'h0, w, a, d};
        @(posedge SYSTEM_CLOCK);
        PENABLE <= 1'h1;
        do @(posedge SYSTEM_CLOCK); while (PREADY !== 1'h1 && ++k < 40);
        chk("apb ready", PREADY, 32'h1);
        rd = PRDATA;
        er = PSLVERR;
        {PSEL, PENABLE} <= 2'h0;
        @(posedge SYSTEM_CLOCK);
    endtask
    task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
        apb(1'h0, a, 32'h0);
        chk(nm, rd, exp);
    endtask
    task automatic tick(input int m);
        repeat (m) @(posedge SYSTEM_CLOCK);
    endtask
    // counts clock enable pulses of core and peripherals
    task automatic see(input int m);
        c = 0;
        p = 0;
        g = 16'h0000;
        repeat (m) begin
            @(posedge SYSTEM_CLOCK);
            g |= gen;
            c += int'(ce === 1'h1);
            p += int'(pe === 1'h1);
        end
    endtask
    task automatic boot();
        n = 0;
        do @(posedge SYSTEM_CLOCK); while (crr !== 1'h0 && ++n < 400);
        chk("boot length", n >= 158 && n <= 166, 32'h1);
    endtask
    task automatic report_and_stop();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    always @(posedge SYSTEM_CLOCK) if (++cyc == 20000) begin
        errors++;
        report_and_stop();
    end
    initial begin
        tick(16);
        RST <= 1'h0;
        boot();
        rdchk("gates", OFS_GATES, 32'hffff);
        rdchk("loc high", OFS_LOC_HIGH, 32'hffff);
        rdchk("loc low", OFS_LOC_LOW, 32'hffff);
        apb(1'h1, OFS_GATES, 32'h0);
        rdchk("gates fixed", OFS_GATES, {16'h0, GATES_FIXED});
        see(2);
        chk("gates off", {g[BIT_SP1], g[BIT_SP0], g[BIT_PWM]}, 32'h0);
        apb(1'h1, OFS_GATES, 32'hd);
        see(2);
        chk("gates on", {g[BIT_SP1], g[BIT_SP0], g[BIT_PWM]}, 32'h7);
        apb(1'h1, OFS_LOC_HIGH, 32'h0);
        rdchk("loc high ones", OFS_LOC_HIGH, 32'hfffc);
        tick(6);
        ofs <= 6'h2a;
        apb(1'h1, OFS_LOC_LOW, 32'h1234);
        tick(6);
        chk("short address", sio, {2'h0, 16'h1234, 6'h2a});
        chk("debug open", dok, 32'h1);
        exm <= 1'h1;
        tick(3);
        chk("debug blocked", dok, 32'h0);
        rdchk("unmapped", 8'h3c, 32'h0);
        chk("unmapped err", er, 32'h1);
        $display("registers done");
        wt <= 1'h1;
        tick(4);
        see(8);
        chk("wait core", c, 32'h0);
        chk("wait periph", p, 32'h4);
        {wt, irq_req} <= 2'h1;
        tick(4);
        see(8);
        chk("woken core", c, 32'h4);
        // stop twice; woken first by CAN activity, then by external interrupt
        for (int i = 0; i < 2; i++) begin
            {stp, irq_req} <= 2'h3;
            tick(4);
            see(8);
            chk("stop clocks", c + p, 32'h0);
            {stp, irq_req, can, xi} <= {2'h0, 2'h2 >> i};
            tick(4);
            {can, xi} <= 2'h0;
            see(8);
            chk("stop wake", c, 32'h4);
        end
        apb(1'h1, OFS_CONTROL, 32'h2);
        wt <= 1'h1;
        tick(4);
        see(8);
        chk("wait held off", c, 32'h4);
        apb(1'h1, OFS_CONTROL, 32'h4);
        apb(1'h1, OFS_CONTROL, 32'h0);
        tick(4);
        see(8);
        chk("wait disabled", c, 32'h4);
        wt <= 1'h0;
        $display("power modes done");
        for (int i = 0; i < 4; i++) begin
            if (i < 3) {xr, por, wd} <= 3'h4 >> i;
            else apb(1'h1, OFS_CONTROL, 32'h1);
            tick(2);
            chk("source reset", {chr, crr}, 32'h3);
            {xr, por, wd} <= 3'h0;
            if (i == 1) begin
                tick(30);
                por <= 1'h1;
                tick(2);
                por <= 1'h0;
            end
            boot();
        end
        $display("resets done");
        report_and_stop();
    end
endmodule
`default_nettype wire

// [logic/scrc_pkg.sv]
// constants for the system clock and reset control block
// assumes an APB master on one clock; offsets are byte addresses (index times four)
// Notes on behaviour
// - clock gate bit set passes peripheral clock
// - gate bit 1 reads one, ignores writes
// - short I/O takes low six bits only
// - high location bits 1:0 give 23:22
// - low location holds address bits 21:6
// - location pair resets to all ones
// - new location used six cycles after the write
// - moved location plus external bit blocks debug
// - system clocks run at half master clock
// - run mode keeps core and peripheral clocks active; gate enables follow gates_reg once the reset sequence reaches RS_PERIPH
// - wait stops core, interrupt wakes it
// - stop gates clocks, woken by CAN activity, external interrupt or any reset source
// - peripherals clocked from peripheral bus clock
// - control write disables stop and wait
// - four reset sources, two async two sync
// - power-on reset while any detector low
// - reset phases 64, 32, 32, 32 clocks
// - reset released only on clock edge
`default_nettype none
package scrc_pkg;
    localparam logic [7:0]  OFS_CONTROL   = 8'h00;
    localparam logic [7:0]  OFS_STATUS    = 8'h04;
    // register indices; the bus address is four times the index
    localparam logic [7:0]  IDX_GATES     = 8'h0c;
    localparam logic [7:0]  IDX_LOC_HIGH  = 8'h0d;
    localparam logic [7:0]  IDX_LOC_LOW   = 8'h0e;
    localparam logic [7:0]  OFS_GATES     = {IDX_GATES[5:0], 2'b00};
    localparam logic [7:0]  OFS_LOC_HIGH  = {IDX_LOC_HIGH[5:0], 2'b00};
    localparam logic [7:0]  OFS_LOC_LOW   = {IDX_LOC_LOW[5:0], 2'b00};
    localparam logic [15:0] GATES_RESET   = 16'hffff;
    localparam logic [15:0] GATES_FIXED   = 16'hc000 | 16'h0800 | 16'h0200 | 16'h0080 | 16'h0002;
    localparam logic [15:0] LOC_RESET     = 16'hffff;
    localparam logic [15:0] LOC_HIGH_ONES = 16'hfffc;
    localparam int          BIT_SP1       = 3;
    localparam int          BIT_SP0       = 2;
    localparam int          BIT_PWM       = 0;
    localparam int          CTL_SWRST     = 0;
    localparam int          CTL_TMPDIS    = 1;
    localparam int          CTL_PERMDIS   = 2;
    localparam int          LOC_DELAY     = 5;
    localparam logic [6:0]  CNT_STAB      = 7'd64;
    localparam logic [6:0]  CNT_PHASE     = 7'd32;
    typedef enum logic [1:0] {PM_RUN, PM_WAIT, PM_STOP} scrc_mode_t;
    typedef enum logic [2:0] {RS_HOLD, RS_STAB, RS_CLK, RS_PERIPH, RS_CORE, RS_DONE}
        scrc_rst_t;
endpackage
`default_nettype wire

// [logic/scrc_top.sv]
// system clock gating, short I/O address location, power modes, reset sequencer
// assumes async reset sources already brought to the system clock by the pad logic
//
// Register access over APB was decided locally.
`default_nettype none
module scrc_top
    import scrc_pkg::*;
(
    input  wire logic        SYSTEM_CLOCK,
    input  wire logic        RST,
    input  wire logic        MASTER_CLK_EN,
    input  wire logic        EXT_RESET,
    input  wire logic        POR_DET_LOW,
    input  wire logic        WDOG_RESET,
    input  wire logic        CORE_STOP_REQ,
    input  wire logic        CORE_WAIT_REQ,
    input  wire logic        PERIPH_IRQ,
    input  wire logic        EXT_IRQ,
    input  wire logic        CAN_ACTIVITY,
    input  wire logic        EXTERNAL_MEMORY_BIT,
    input  wire logic [5:0]  SHORT_IO_OFFSET,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic [31:0]      PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    output logic [23:0]      SHORT_IO_ADDRESS,
    output logic             DEBUG_ACCESS_OK,
    output logic             CORE_CLK_EN,
    output logic             PERIPH_CLK_EN,
    output logic [15:0]      PERIPH_GATE_EN,
    output logic             CHIP_RESET,
    output logic             PERIPH_RESET,
    output logic             CORE_RESET
);
    logic [15:0] gates_reg;
    logic [15:0] loc_high_reg;
    logic [15:0] loc_low_reg;
    logic [17:0] loc_pipe_reg [LOC_DELAY];
    logic        tmp_dis_reg;
    logic        perm_dis_reg;
    logic        sw_rst_reg;
    logic        div_reg;
    scrc_mode_t  mode_reg;
    scrc_rst_t   rst_state_reg;
    logic [6:0]  rst_cnt_reg;
    logic        wr_en;
    logic        rd_en;
    logic        addr_ok;
    logic        any_src;
    logic        run_ok;
    logic [31:0] rd_data;

    assign wr_en   = PSEL && PENABLE && PWRITE;
    assign rd_en   = PSEL && PENABLE && !PWRITE;
    assign addr_ok = PADDR == OFS_CONTROL || PADDR == OFS_STATUS || PADDR == OFS_GATES
                  || PADDR == OFS_LOC_HIGH || PADDR == OFS_LOC_LOW;
    // software reset is synchronous, the others arrive level
    assign any_src = EXT_RESET || POR_DET_LOW || WDOG_RESET || sw_rst_reg;
    assign run_ok  = rst_state_reg == RS_DONE;

    always_comb begin
        rd_data = 32'h0000_0000;
        case (PADDR)
            OFS_CONTROL:  rd_data = {29'h0, perm_dis_reg, tmp_dis_reg, 1'b0};
            OFS_STATUS:   rd_data = {24'h0, 2'h0, rst_state_reg, 1'b0, mode_reg};
            OFS_GATES:    rd_data = {16'h0, gates_reg | GATES_FIXED};
            OFS_LOC_HIGH: rd_data = {16'h0, loc_high_reg | LOC_HIGH_ONES};
            OFS_LOC_LOW:  rd_data = {16'h0, loc_low_reg};
            default:      rd_data = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge SYSTEM_CLOCK) begin
        if (RST) begin
            PRDATA  <= 32'h0000_0000;
            PREADY  <= 1'b0;
            PSLVERR <= 1'b0;
        end else begin
            PREADY  <= PSEL && !PENABLE;
            PSLVERR <= PSEL && !PENABLE && !addr_ok;
            if (PSEL && !PENABLE) begin
                PRDATA <= rd_data;
            end
        end
    end

    // registers take effect when PREADY is seen high with the access phase
    always_ff @(posedge SYSTEM_CLOCK) begin
        if (RST) begin
            gates_reg    <= GATES_RESET;
            loc_high_reg <= LOC_RESET;
            loc_low_reg  <= LOC_RESET;
        end else if (wr_en && PREADY) begin
            if (PADDR == OFS_GATES) begin
                gates_reg <= PWDATA[15:0] | GATES_FIXED;
            end
            if (PADDR == OFS_LOC_HIGH) begin
                loc_high_reg <= PWDATA[15:0] | LOC_HIGH_ONES;
            end
            if (PADDR == OFS_LOC_LOW) begin
                loc_low_reg <= PWDATA[15:0];
            end
        end
    end

    // permanent disable survives until reset only
    always_ff @(posedge SYSTEM_CLOCK) begin
        if (RST) begin
            tmp_dis_reg  <= 1'b0;
            perm_dis_reg <= 1'b0;
            sw_rst_reg   <= 1'b0;
        end else begin
            sw_rst_reg <= wr_en && PREADY && PADDR == OFS_CONTROL && PWDATA[CTL_SWRST];
            if (wr_en && PREADY && PADDR == OFS_CONTROL) begin
                tmp_dis_reg  <= PWDATA[CTL_TMPDIS];
                perm_dis_reg <= perm_dis_reg || PWDATA[CTL_PERMDIS];
            end
        end
    end

    // location value travels a five stage pipeline before use
    genvar gi;
    generate
        for (gi = 0; gi < LOC_DELAY; gi++) begin : g_pipe
            // first stage elaborated apart so no stage indexes below zero
            if (gi == 0) begin : g_head
                always_ff @(posedge SYSTEM_CLOCK) begin
                    if (RST) begin
                        loc_pipe_reg[gi] <= 18'h3ffff;
                    end else begin
                        loc_pipe_reg[gi] <= {loc_high_reg[1:0], loc_low_reg};
                    end
                end
            end else begin : g_tail
                always_ff @(posedge SYSTEM_CLOCK) begin
                    if (RST) begin
                        loc_pipe_reg[gi] <= 18'h3ffff;
                    end else begin
                        loc_pipe_reg[gi] <= loc_pipe_reg[gi-1];
                    end
                end
            end
        end
    endgenerate

    always_ff @(posedge SYSTEM_CLOCK) begin
        if (RST) begin
            SHORT_IO_ADDRESS <= 24'hffffff;
            DEBUG_ACCESS_OK  <= 1'b1;
        end else begin
            SHORT_IO_ADDRESS <= {loc_pipe_reg[LOC_DELAY-1], SHORT_IO_OFFSET};
            DEBUG_ACCESS_OK  <= !(loc_pipe_reg[LOC_DELAY-1] != 18'h3ffff
                                  && EXTERNAL_MEMORY_BIT);
        end
    end

    // system clock enable toggles at half the master rate
    always_ff @(posedge SYSTEM_CLOCK) begin
        if (RST) begin
            div_reg <= 1'b0;
        end else if (MASTER_CLK_EN) begin
            div_reg <= !div_reg;
        end
    end

    always_ff @(posedge SYSTEM_CLOCK) begin
        if (RST || any_src) begin
            mode_reg <= PM_RUN;
        end else begin
            case (mode_reg)
                PM_RUN: begin
                    if (CORE_STOP_REQ && !tmp_dis_reg && !perm_dis_reg) begin
                        mode_reg <= PM_STOP;
                    end else if (CORE_WAIT_REQ && !tmp_dis_reg && !perm_dis_reg) begin
                        mode_reg <= PM_WAIT;
                    end
                end
                PM_WAIT: if (PERIPH_IRQ) begin
                    mode_reg <= PM_RUN;
                end
                // resets also leave stop via any_src
                PM_STOP: if (CAN_ACTIVITY || EXT_IRQ) begin
                    mode_reg <= PM_RUN;
                end
                default: mode_reg <= PM_RUN;
            endcase
        end
    end

    always_ff @(posedge SYSTEM_CLOCK) begin
        if (RST) begin
            CORE_CLK_EN    <= 1'b0;
            PERIPH_CLK_EN  <= 1'b0;
            PERIPH_GATE_EN <= 16'h0000;
        end else begin
            CORE_CLK_EN    <= div_reg && mode_reg == PM_RUN;
            PERIPH_CLK_EN  <= div_reg && mode_reg != PM_STOP;
            PERIPH_GATE_EN <= {16{div_reg && mode_reg != PM_STOP
                                && rst_state_reg >= RS_PERIPH}} & gates_reg;
        end
    end

    // phases step on the clock edge; any source restarts the count
    always_ff @(posedge SYSTEM_CLOCK) begin
        if (RST || any_src) begin
            rst_state_reg <= RS_HOLD;
            rst_cnt_reg   <= 7'd0;
        end else begin
            case (rst_state_reg)
                RS_HOLD: begin
                    rst_state_reg <= RS_STAB;
                    rst_cnt_reg   <= CNT_STAB - 7'd1;
                end
                RS_STAB, RS_CLK, RS_PERIPH, RS_CORE: begin
                    if (rst_cnt_reg == 7'd0) begin
                        rst_state_reg <= scrc_rst_t'(rst_state_reg + 3'd1);
                        rst_cnt_reg   <= CNT_PHASE - 7'd1;
                    end else begin
                        rst_cnt_reg <= rst_cnt_reg - 7'd1;
                    end
                end
                RS_DONE: rst_cnt_reg <= 7'd0;
                default: rst_state_reg <= RS_HOLD;
            endcase
        end
    end

    always_ff @(posedge SYSTEM_CLOCK) begin
        if (RST) begin
            CHIP_RESET   <= 1'b1;
            PERIPH_RESET <= 1'b1;
            CORE_RESET   <= 1'b1;
        end else begin
            CHIP_RESET   <= rst_state_reg <= RS_STAB || any_src;
            PERIPH_RESET <= rst_state_reg <= RS_CLK || any_src;
            CORE_RESET   <= !run_ok || any_src;
        end
    end
endmodule
`default_nettype wire
